// ---- rtl/sac_pkg.sv ----
// Purpose: shared constants for the converter control block
// Assumes: 8-bit register port, converter clock derived from CLOCK
// Notes: offsets are byte addresses on the register port
package sac_pkg;

  // register offsets
  localparam logic [7:0] SAC_OFS_MODE = 8'hb1;
  localparam logic [7:0] SAC_OFS_RESULT_HIGH = 8'hb2;
  localparam logic [7:0] SAC_OFS_RATE_LOW = 8'hb3;

  // mode register field positions
  localparam int SAC_BIT_ENABLE = 7;
  localparam int SAC_BIT_START = 6;
  localparam int SAC_BIT_EOC = 5;
  localparam int SAC_BIT_CHANNEL_GLOBAL_ENABLE = 4;
  localparam int SAC_CHS_LSB = 0;
  localparam int SAC_CHS_W = 4;

  // rate and low-nibble register field positions
  localparam int SAC_BIT_CKS1 = 6;
  localparam int SAC_BIT_RES = 5;
  localparam int SAC_BIT_CKS0 = 4;
  localparam int SAC_LOW_LSB = 0;

  // reset values
  localparam logic [7:0] SAC_MODE_RESET = 8'h00;
  localparam logic SAC_RES_RESET = 1'b0;
  localparam logic [1:0] SAC_CKS_RESET = 2'h0;

  // divider codes and their ratios
  localparam logic [1:0] SAC_CKS_DIV16 = 2'h0;
  localparam logic [1:0] SAC_CKS_DIV8 = 2'h1;
  localparam logic [1:0] SAC_CKS_DIV1 = 2'h2;
  localparam logic [1:0] SAC_CKS_DIV2 = 2'h3;
  localparam int SAC_DIV16 = 16;
  localparam int SAC_DIV8 = 8;
  localparam int SAC_DIV1 = 1;
  localparam int SAC_DIV2 = 2;

  // conversion length in periods of converter clock / 4
  localparam int SAC_PERIODS_12 = 16;
  localparam int SAC_PERIODS_8 = 12;
  localparam int SAC_QUARTER = 4;

  // highest legal channel code; above it is reserved
  localparam logic [3:0] SAC_CHAN_MAX = 4'hc;

  // interrupt vector address
  localparam logic [7:0] SAC_IRQ_VECTOR = 8'h08;

  typedef enum logic [0:0] {
    SAC_ST_IDLE = 1'b0,
    SAC_ST_CONV = 1'b1
  } sac_state_e;

endpackage

// ---- rtl/sac_conv_timer.sv ----
// Purpose: converter clock divider and conversion length counter
// Assumes: run stays high for the whole conversion, drops to abort
// Notes: done is a one-cycle pulse at the last CLOCK of the conversion
`timescale 1ns/1ps
module sac_conv_timer
  import sac_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic [1:0] div_code,
  input wire logic res12,
  // status
  output logic done
);

  logic [4:0] ratio;
  logic [4:0] pre_cnt;
  logic [6:0] tick_total;
  logic [6:0] tick_cnt;
  logic tick;

  // divider code to ratio
  always_comb begin
    unique case (div_code)
      SAC_CKS_DIV16: ratio = 5'(SAC_DIV16);
      SAC_CKS_DIV8: ratio = 5'(SAC_DIV8);
      SAC_CKS_DIV1: ratio = 5'(SAC_DIV1);
      SAC_CKS_DIV2: ratio = 5'(SAC_DIV2);
    endcase
  end

  assign tick_total = res12 ? 7'(SAC_PERIODS_12 * SAC_QUARTER) : 7'(SAC_PERIODS_8 * SAC_QUARTER);
  assign tick = run && (pre_cnt == ratio - 5'd1);
  assign done = tick && (tick_cnt == tick_total - 7'd1);

  // converter clock prescaler
  always_ff @(posedge clk) begin
    if (rst || !run || tick) begin
      pre_cnt <= 5'd0;
    end else begin
      pre_cnt <= pre_cnt + 5'd1;
    end
  end

  // converter clock periods elapsed
  always_ff @(posedge clk) begin
    if (rst || !run || done) begin
      tick_cnt <= 7'd0;
    end else if (tick) begin
      tick_cnt <= tick_cnt + 7'd1;
    end
  end

endmodule

// ---- rtl/sac_adc_ctrl.sv ----
// Purpose: control and result logic of a 13-input SAR converter
// Assumes: CLOCK is the high-speed oscillator; analog core result valid at end
// Notes: register port with read data one cycle after the read strobe
// Overview of operation
// RQ1 - enable bit powers the converter; cleared it stops everything
// RQ2 - start bit begins a conversion, clearing stops it; auto-cleared at end
// RQ3 - conversion begins only with both enable and start set
// RQ4 - end flag reads 0 during conversion, 1 at end with start cleared
// RQ5 - completion sets end flag and request flag and stores the result
// RQ6 - enabled request flag raises an interrupt to vector address 8
// RQ7 - enabled converter interrupt wakes the system from green mode
// RQ8 - global channel bit connects the selected input, else none
// RQ9 - channel code n selects input n up to 12; 13 to 15 reserved
// RQ10 - software avoids internal 2.5V or 3.5V reference on the fixed channel
// RQ11 - clock rate field from bits 6 and 4 divides by 16, 8, 1, 2
// RQ12 - resolution bit chooses 8-bit when clear, 12-bit when set
// RQ13 - software finishes all settings before setting the start bit
// RQ14 - 12-bit result splits into high byte and low nibble
// RQ15 - 8-bit result lives in the high byte; low nibble meaningless
// RQ16 - result buffers are read-only and not reset
// RQ17 - result is unsigned 0 to 4095 from the analog core
// RQ18 - software clears enable before power saving
// RQ19 - conversion lasts 16 or 12 periods of converter clock over 4
// RQ20 - request flag holds until cleared; each completion sets it again
`timescale 1ns/1ps
module sac_adc_ctrl
  import sac_pkg::*;
#(
  parameter int RESULT_W = 12,
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  // analog core
  output logic CORE_POWER,
  output logic CORE_START,
  output logic CORE_RES12,
  input wire logic [RESULT_W-1:0] CORE_RESULT,
  // input multiplexer
  output logic CHANNEL_CONNECT,
  output logic [3:0] CHANNEL_SEL,
  // interrupt and power mode
  input wire logic IRQ_ENABLE,
  input wire logic IRQ_FLAG_CLEAR,
  input wire logic GREEN_MODE,
  output logic IRQ_FLAG,
  output logic IRQ_REQUEST,
  output logic [7:0] IRQ_VECTOR,
  output logic WAKE
);

  generate
    if (RESULT_W != 12) begin : g_bad_width
      $error("result width must be 12");
    end
    if (ADDR_W != 8) begin : g_bad_addr
      $error("address width must be 8");
    end
    // the timer has a 5-bit prescaler and a 7-bit period counter
    if (SAC_DIV16 > 31 || SAC_DIV8 > 31 || SAC_DIV2 > 31) begin : g_bad_ratio
      $error("divider ratio exceeds the prescaler");
    end
    if (SAC_DIV1 < 1 || SAC_DIV2 < 1 || SAC_DIV8 < 1) begin : g_zero_ratio
      $error("divider ratio must be at least one");
    end
    if (SAC_PERIODS_12 * SAC_QUARTER > 127) begin : g_bad_len12
      $error("12-bit conversion length exceeds the period counter");
    end
    if (SAC_PERIODS_8 * SAC_QUARTER > 127) begin : g_bad_len8
      $error("8-bit conversion length exceeds the period counter");
    end
  endgenerate

  sac_state_e state;
  sac_state_e next_state;

  logic converter_enable;
  logic conversion_start;
  logic end_of_conv;
  logic channel_global_enable;
  logic [3:0] channel_select;
  logic [1:0] conv_clock_divider;
  logic resolution_select;
  logic [7:0] result_high_byte;
  logic [3:0] result_low_nibble;
  logic conv_irq_flag;
  logic [1:0] run_divider;
  logic run_res12;

  logic wr_mode;
  logic wr_rate;
  logic begin_conv;
  logic abort_conv;
  logic conv_done;
  logic [7:0] mode_read;
  logic [7:0] rate_read;

  // address decode, used for both writes and reads
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_mode = WR && hit(ADDR, SAC_OFS_MODE);
  assign wr_rate = WR && hit(ADDR, SAC_OFS_RATE_LOW);

  // RQ3 both bits set
  assign begin_conv = (state == SAC_ST_IDLE) && converter_enable && conversion_start;

  // RQ1 RQ2 stop on clear
  assign abort_conv = (state == SAC_ST_CONV) && (!converter_enable || !conversion_start);

  // conversion state
  always_comb begin
    next_state = state;
    unique case (state)
      SAC_ST_IDLE: begin
        if (begin_conv) begin
          next_state = SAC_ST_CONV;
        end
      end
      SAC_ST_CONV: begin
        if (abort_conv || conv_done) begin
          next_state = SAC_ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      state <= SAC_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // RQ19 conversion length
  sac_conv_timer u_timer (
    .clk(CLOCK),
    .rst(RST),
    .run((state == SAC_ST_CONV) && !abort_conv),
    .div_code(run_divider),
    .res12(run_res12),
    .done(conv_done)
  );

  // settings frozen for the running conversion
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      run_divider <= SAC_CKS_RESET;
      run_res12 <= SAC_RES_RESET;
    end else if (begin_conv) begin
      run_divider <= conv_clock_divider;
      run_res12 <= resolution_select;
    end
  end

  // RQ1 enable bit
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      converter_enable <= SAC_MODE_RESET[SAC_BIT_ENABLE];
    end else if (wr_mode) begin
      converter_enable <= WDATA[SAC_BIT_ENABLE];
    end
  end

  // RQ2 start bit, a fresh write beats the auto clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      conversion_start <= SAC_MODE_RESET[SAC_BIT_START];
    end else if (wr_mode) begin
      conversion_start <= WDATA[SAC_BIT_START];
    end else if (conv_done) begin
      conversion_start <= 1'b0;
    end
  end

  // RQ4 end flag, hardware set wins
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      end_of_conv <= SAC_MODE_RESET[SAC_BIT_EOC];
    end else if (conv_done) begin
      end_of_conv <= 1'b1;
    end else if (begin_conv) begin
      end_of_conv <= 1'b0;
    end else if (wr_mode) begin
      end_of_conv <= WDATA[SAC_BIT_EOC];
    end
  end

  // RQ8 RQ9 channel fields
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      channel_global_enable <= SAC_MODE_RESET[SAC_BIT_CHANNEL_GLOBAL_ENABLE];
      channel_select <= SAC_MODE_RESET[SAC_CHS_LSB +: SAC_CHS_W];
    end else if (wr_mode) begin
      channel_global_enable <= WDATA[SAC_BIT_CHANNEL_GLOBAL_ENABLE];
      channel_select <= WDATA[SAC_CHS_LSB +: SAC_CHS_W];
    end
  end

  // RQ11 RQ12 rate and resolution
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      conv_clock_divider <= SAC_CKS_RESET;
      resolution_select <= SAC_RES_RESET;
    end else if (wr_rate) begin
      conv_clock_divider <= {WDATA[SAC_BIT_CKS1], WDATA[SAC_BIT_CKS0]};
      resolution_select <= WDATA[SAC_BIT_RES];
    end
  end

  // RQ5 RQ14 RQ15 RQ16 RQ17 result capture, no reset
  always_ff @(posedge CLOCK) begin
    if (conv_done) begin
      result_high_byte <= CORE_RESULT[11:4];
      result_low_nibble <= CORE_RESULT[3:0];
    end
  end

  // RQ5 RQ20 request flag, set beats clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      conv_irq_flag <= 1'b0;
    end else if (conv_done) begin
      conv_irq_flag <= 1'b1;
    end else if (IRQ_FLAG_CLEAR) begin
      conv_irq_flag <= 1'b0;
    end
  end

  // core start pulse, one cycle as the conversion begins
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CORE_START <= 1'b0;
    end else begin
      CORE_START <= begin_conv;
    end
  end

  // RQ1 core power
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CORE_POWER <= 1'b0;
    end else begin
      CORE_POWER <= converter_enable;
    end
  end

  // RQ12 resolution to core
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CORE_RES12 <= SAC_RES_RESET;
    end else if (begin_conv) begin
      CORE_RES12 <= resolution_select;
    end
  end

  // RQ8 RQ9 multiplexer; reserved codes connect nothing
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      CHANNEL_CONNECT <= 1'b0;
      CHANNEL_SEL <= 4'h0;
    end else begin
      CHANNEL_CONNECT <= converter_enable && channel_global_enable &&
                         (channel_select <= SAC_CHAN_MAX);
      CHANNEL_SEL <= channel_select;
    end
  end

  // RQ6 interrupt request and vector
  assign IRQ_FLAG = conv_irq_flag;
  assign IRQ_REQUEST = conv_irq_flag && IRQ_ENABLE;
  assign IRQ_VECTOR = SAC_IRQ_VECTOR;

  // RQ7 wake from green mode
  assign WAKE = IRQ_REQUEST && GREEN_MODE;

  // read views
  always_comb begin
    mode_read = 8'h00;
    mode_read[SAC_BIT_ENABLE] = converter_enable;
    mode_read[SAC_BIT_START] = conversion_start;
    // RQ4 end flag low once start is taken
    mode_read[SAC_BIT_EOC] = end_of_conv && !begin_conv;
    mode_read[SAC_BIT_CHANNEL_GLOBAL_ENABLE] = channel_global_enable;
    mode_read[SAC_CHS_LSB +: SAC_CHS_W] = channel_select;
    rate_read = 8'h00;
    rate_read[SAC_BIT_CKS1] = conv_clock_divider[1];
    rate_read[SAC_BIT_RES] = resolution_select;
    rate_read[SAC_BIT_CKS0] = conv_clock_divider[0];
    rate_read[SAC_LOW_LSB +: 4] = result_low_nibble;
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      if (hit(ADDR, SAC_OFS_MODE)) begin
        RDATA <= mode_read;
      end else if (hit(ADDR, SAC_OFS_RESULT_HIGH)) begin
        RDATA <= result_high_byte;
      end else if (hit(ADDR, SAC_OFS_RATE_LOW)) begin
        RDATA <= rate_read;
      end else begin
        RDATA <= 8'h00;
      end
    end else begin
      RDATA <= 8'h00;
    end
  end

endmodule

// ---- verification/sac_adc_ctrl_asserts.sv ----
// Purpose: port checks for the converter control block
// Assumes: bound to every instance of sac_adc_ctrl
// Notes: one clock domain, reset disables all checks
`timescale 1ns/1ps
module sac_adc_ctrl_asserts
  import sac_pkg::*;
#(
  parameter int RESULT_W = 12,
  parameter int ADDR_W = 8
)
(
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  // analog core
  input wire logic CORE_POWER,
  input wire logic CORE_START,
  input wire logic CORE_RES12,
  input wire logic [RESULT_W-1:0] CORE_RESULT,
  // input multiplexer
  input wire logic CHANNEL_CONNECT,
  input wire logic [3:0] CHANNEL_SEL,
  // interrupt and power mode
  input wire logic IRQ_ENABLE,
  input wire logic IRQ_FLAG_CLEAR,
  input wire logic GREEN_MODE,
  input wire logic IRQ_FLAG,
  input wire logic IRQ_REQUEST,
  input wire logic [7:0] IRQ_VECTOR,
  input wire logic WAKE
);
  default clocking @(posedge CLOCK);
  endclocking
  default disable iff (RST);
  wire logic wr_en = WDATA[SAC_BIT_ENABLE];

  vector_fixed_a: assert property (IRQ_VECTOR == SAC_IRQ_VECTOR)
    else $error("bad vector");
  irq_gate_a: assert property (IRQ_REQUEST == (IRQ_FLAG && IRQ_ENABLE))
    else $error("bad request");
  wake_gate_a: assert property (WAKE == (IRQ_REQUEST && GREEN_MODE))
    else $error("bad wake");
  flag_hold_a: assert property (IRQ_FLAG && !IRQ_FLAG_CLEAR |=> IRQ_FLAG)
    else $error("flag lost");
  power_follow_a: assert property (WR && ADDR == 8'hb1 |-> ##2 CORE_POWER == $past(wr_en, 2))
    else $error("power does not follow enable");
  start_power_a: assert property (CORE_START |-> CORE_POWER)
    else $error("start while unpowered");
  start_pulse_a: assert property (CORE_START |=> !CORE_START)
    else $error("start pulse too long");
  res_latch_a: assert property (CORE_START |=> ##1 $stable(CORE_RES12) [*6])
    else $error("resolution changed in conversion");
  chan_legal_a: assert property (CHANNEL_CONNECT |-> CHANNEL_SEL <= SAC_CHAN_MAX)
    else $error("reserved channel connected");
  flag_power_a: assert property ($rose(IRQ_FLAG) |-> CORE_POWER)
    else $error("flag set while unpowered");

  cover property (CORE_START);
  cover property ($rose(IRQ_FLAG));
  cover property (WAKE);
endmodule

// ---- verification/sac_core_model.sv ----
// Purpose: behavioural analog core and input multiplexer
// Assumes: sample taken on a start pulse while connected, held while powered until the next one; inverted every cycle while unpowered
// Notes: result depends on channel so the bench can predict it
`timescale 1ns/1ps
module sac_core_model #(
  parameter logic [11:0] BASE = 12'h35a
)
(
  // clock
  input wire logic clk,
  // from the control block
  input wire logic power,
  input wire logic start,
  input wire logic connect,
  input wire logic [3:0] chan,
  // result
  output logic [11:0] result
);
  logic [11:0] held = 12'h000;
  // powered connected sample, BASE offset by the channel in the top nibble
  always_ff @(posedge clk) begin
    if (start && power && connect) begin
      held <= BASE + {chan, 8'h00};
    end else if (!power) begin
      held <= ~held;
    end
  end
  assign result = held;
endmodule

// ---- verification/tb_sac_adc_ctrl.sv ----
// Purpose: self-checking bench for the converter control block
// Assumes: core model answers every conversion
// Notes: every divider code and both resolutions are converted
`timescale 1ns/1ps
module tb_sac_adc_ctrl;
  import sac_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic irq_enable = 1'b0;
  logic irq_clear = 1'b0;
  logic green = 1'b0;
  logic [7:0] rdata, vector, got;
  logic power, start, res12, connect, irq_flag, irq_req, wake;
  logic [3:0] chan;
  logic [11:0] result;
  logic [7:0] mux_cfg [3] = '{8'h9d, 8'h8c, 8'h9c};
  logic mux_on [3] = '{1'b0, 1'b0, 1'b1};
  int n_mismatch = 0;
  int checks = 0;

  sac_adc_ctrl i_sac_adc_ctrl (
    .CLOCK(clock), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .CORE_POWER(power), .CORE_START(start), .CORE_RES12(res12),
    .CORE_RESULT(result), .CHANNEL_CONNECT(connect), .CHANNEL_SEL(chan),
    .IRQ_ENABLE(irq_enable), .IRQ_FLAG_CLEAR(irq_clear), .GREEN_MODE(green),
    .IRQ_FLAG(irq_flag), .IRQ_REQUEST(irq_req), .IRQ_VECTOR(vector), .WAKE(wake)
  );
  sac_core_model i_sac_core_model (
    .clk(clock), .power(power), .start(start), .connect(connect), .chan(chan),
    .result(result)
  );

  initial begin
    forever #10 clock = ~clock;
  end

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    @(posedge clock);
    wr <= 1'b0;
    rd <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic expect8(input logic [7:0] have, input logic [7:0] want);
    checks++;
    if (have !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, have, want);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] want);
    acc(1'b0, a, 8'h00);
    expect8(got, want);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    int i;
    int n;
    logic [1:0] cks;
    logic res;
    logic [3:0] ch;
    logic [11:0] want;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd_chk(SAC_OFS_MODE, 8'h00);
    acc(1'b0, SAC_OFS_RATE_LOW, 8'h00);
    expect8(got & 8'h70, 8'h00);
    acc(1'b1, 8'h40, 8'hff);
    rd_chk(8'h40, 8'h00);
    expect8(vector, 8'h08);
    // start without enable, then an aborted conversion
    acc(1'b1, SAC_OFS_RATE_LOW, 8'h40);
    acc(1'b1, SAC_OFS_MODE, 8'h45);
    repeat (60) @(posedge clock);
    rd_chk(SAC_OFS_MODE, 8'h45);
    acc(1'b1, SAC_OFS_MODE, 8'hc5);
    repeat (10) @(posedge clock);
    acc(1'b1, SAC_OFS_MODE, 8'h85);
    repeat (60) @(posedge clock);
    expect8(irq_flag, 1'b0);
    rd_chk(SAC_OFS_MODE, 8'h85);
    for (i = 0; i < 3; i++) begin
      acc(1'b1, SAC_OFS_MODE, mux_cfg[i]);
      repeat (2) @(posedge clock);
      #1 expect8(connect, mux_on[i]);
      expect8(chan, mux_cfg[i][3:0]);
    end
    for (i = 0; i < 8; i++) begin
      cks = i[2:1];
      res = i[0];
      ch = 4'(i + 5);
      want = 12'h35a + {ch, 8'h00};
      n = (cks == 2'h0 ? 16 : cks == 2'h1 ? 8 : cks == 2'h2 ? 1 : 2) * 4 * (res ? 16 : 12);
      @(posedge clock);
      irq_enable <= i[1];
      green <= i[2];
      acc(1'b1, SAC_OFS_RATE_LOW, {1'b0, cks[1], res, cks[0], 4'h0});
      acc(1'b1, SAC_OFS_MODE, {4'h9, ch});
      acc(1'b1, SAC_OFS_MODE, {4'hd, ch});
      @(posedge clock);
      #1 expect8(start, 1'b1);
      expect8(res12, res);
      repeat (n - 3) @(posedge clock);
      rd_chk(SAC_OFS_MODE, {4'hd, ch});
      repeat (3) @(posedge clock);
      rd_chk(SAC_OFS_MODE, {4'hb, ch});
      rd_chk(SAC_OFS_RESULT_HIGH, want[11:4]);
      acc(1'b0, SAC_OFS_RATE_LOW, 8'h00);
      expect8({got[7:4], 4'h0}, {1'b0, cks[1], res, cks[0], 4'h0});
      expect8(res ? {4'h0, got[3:0]} : 8'h00, res ? {4'h0, want[3:0]} : 8'h00);
      expect8(irq_flag, 1'b1);
      expect8(irq_req, i[1]);
      expect8(wake, i[1] & i[2]);
      @(posedge clock);
      irq_clear <= 1'b1;
      @(posedge clock);
      irq_clear <= 1'b0;
      #1 expect8(irq_flag, 1'b0);
    end
    acc(1'b1, SAC_OFS_RESULT_HIGH, 8'h00);
    acc(1'b1, SAC_OFS_RATE_LOW, 8'hff);
    rd_chk(SAC_OFS_RESULT_HIGH, want[11:4]);
    rd_chk(SAC_OFS_RATE_LOW, {4'h7, want[3:0]});
    acc(1'b1, SAC_OFS_MODE, 8'h00);
    repeat (2) @(posedge clock);
    #1 expect8(power, 1'b0);
    expect8(connect, 1'b0);
    // reset in the first cycle of a conversion
    acc(1'b1, SAC_OFS_MODE, 8'hd0);
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rd_chk(SAC_OFS_MODE, 8'h00);
    acc(1'b0, SAC_OFS_RATE_LOW, 8'h00);
    expect8(got & 8'h70, 8'h00);
    rd_chk(SAC_OFS_RESULT_HIGH, want[11:4]);
    expect8(power, 1'b0);
    report_and_stop();
  end
endmodule

bind sac_adc_ctrl sac_adc_ctrl_asserts #(.RESULT_W(RESULT_W), .ADDR_W(ADDR_W)) i_sac_adc_ctrl_asserts (
  .CLOCK, .RST, .ADDR, .WDATA, .WR, .RD, .RDATA, .CORE_POWER, .CORE_START,
  .CORE_RES12, .CORE_RESULT, .CHANNEL_CONNECT, .CHANNEL_SEL, .IRQ_ENABLE,
  .IRQ_FLAG_CLEAR, .GREEN_MODE, .IRQ_FLAG, .IRQ_REQUEST, .IRQ_VECTOR, .WAKE
);
